// ==== sfid_pkg.sv ====
// constants shared by the flash-port decoder, its host and the link
// assumes both ends share clk at 250 MHz
package sfid_pkg;
  // opcodes
  localparam logic [7:0] OP_WR_EN     = 8'h06;
  localparam logic [7:0] OP_WR_DIS    = 8'h04;
  localparam logic [7:0] OP_RD_STAT   = 8'h05;
  localparam logic [7:0] OP_WR_STAT   = 8'h01;
  localparam logic [7:0] OP_RD        = 8'h03;
  localparam logic [7:0] OP_FAST_RD   = 8'h0b;
  localparam logic [7:0] OP_DUAL_RD   = 8'h3b;
  localparam logic [7:0] OP_PROG      = 8'h02;
  localparam logic [7:0] OP_ERASE64   = 8'hd8;
  localparam logic [7:0] OP_ERASE4    = 8'h20;
  localparam logic [7:0] OP_ERASE_ALL = 8'hc7;
  localparam logic [7:0] OP_PWR_DOWN  = 8'hb9;
  localparam logic [7:0] OP_PART_ID   = 8'hab;
  localparam logic [7:0] OP_MFR_ID    = 8'h90;
  localparam logic [7:0] OP_JEDEC_ID  = 8'h9f;
  // status byte layout
  localparam int         ST_LOCK    = 7;
  localparam int         ST_LATCH   = 1;
  localparam int         ST_BUSY    = 0;
  localparam logic [7:0] ST_WR_MASK = 8'hbc;
  localparam logic [7:0] ST_NV_RST  = 8'h00;
  // bit and byte positions inside a frame
  localparam logic [2:0] BIT_LAST       = 3'h7;
  localparam logic [1:0] DUAL_LAST      = 2'h3;
  localparam logic [3:0] IDX_OPC        = 4'h0;
  localparam logic [3:0] IDX_ADDR_FIRST = 4'h1;
  localparam logic [3:0] IDX_CAP        = 4'h2;
  localparam logic [3:0] IDX_ADDR_LAST  = 4'h3;
  localparam logic [3:0] IDX_DUMMY      = 4'h4;
  localparam logic [3:0] IDX_MAX        = 4'hf;
  localparam logic [3:0] LEN_OPC        = 4'h1;
  localparam logic [3:0] LEN_WSTAT      = 4'h2;
  localparam logic [3:0] LEN_ERASE      = 4'h4;
  localparam logic [3:0] LEN_PROG_MIN   = 4'h5;
  typedef enum logic [1:0] {
    FR_IDLE = 2'b00,
    FR_OPC  = 2'b01,
    FR_BODY = 2'b11,
    FR_SKIP = 2'b10
  } sfid_frame_e;
  typedef enum logic [2:0] {
    SRC_NONE, SRC_STAT, SRC_MEM, SRC_MAKER, SRC_PART, SRC_TYPE, SRC_CAP
  } sfid_src_e;
  // host register map, byte addresses
  localparam logic [3:0]  HA_CTRL       = 4'h0;
  localparam logic [3:0]  HA_DATA       = 4'h4;
  localparam logic [3:0]  HA_STAT       = 4'h8;
  localparam int          HC_SEL        = 0;
  localparam int          HC_DUAL       = 1;
  localparam int          HS_BUSY       = 0;
  localparam logic [3:0]  HBITS_SINGLE  = 4'h8;
  localparam logic [3:0]  HBITS_DUAL    = 4'h4;
  localparam logic [1:0]  HTRANS_NONSEQ = 2'b10;
  // link clock made by the host
  localparam int LINK_PERIOD_NS = 80;
  localparam int CLK_PERIOD_NS  = 4;
  localparam int LINK_HALF_CYC  = LINK_PERIOD_NS / (2 * CLK_PERIOD_NS);
endpackage : sfid_pkg

// ==== sfid_link_if.sv ====
// serial link between flash-port decoder and host
// assumes a weak pull-up on the shared io line
`timescale 1ns/10ps
interface sfid_link_if;
  logic cs_n;
  logic sclk;
  logic so;
  logic host_io_o;
  logic host_io_oe_n;
  logic dev_io_o;
  logic dev_io_oe_n;
  logic io_in;

  // resolved level of the shared line
  assign io_in = !dev_io_oe_n ? dev_io_o :
                 (!host_io_oe_n ? host_io_o : 1'b1);

  modport dev  (input cs_n, sclk, io_in,
                output so, dev_io_o, dev_io_oe_n);
  modport host (output cs_n, sclk, host_io_o, host_io_oe_n,
                input so, io_in);
endinterface : sfid_link_if

// ==== sfid_sync.sv ====
// two-flop synchroniser with edge detect behind it
// assumes inputs are asynchronous to clk
`timescale 1ns/10ps
module sfid_sync #(
  parameter int           W    = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);
  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;
  logic [W-1:0] prev_r;

  always_ff @(posedge clk) begin
    if (srst) begin
      meta_r <= INIT;
      sync_r <= INIT;
      prev_r <= INIT;
    end else begin
      meta_r <= d;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  // edges look only at the second and third flop
  assign q    = sync_r;
  assign rise = sync_r & ~prev_r;
  assign fall = ~sync_r & prev_r;
endmodule : sfid_sync

// ==== sfid_dev.sv ====
// instruction framing and decoding of the flash serial port
// assumes cycle engine, array and protection decode sit outside;
// mem_rd_data follows mem_addr combinationally within one clk
// Notes on behaviour
// - select falling starts a new frame
// - first eight bits form the opcode
// - msb first, sampled on rising link clock
// - select rising ends and executes frame
// - write-type frames need whole bytes
// - while busy only status read accepted
// - fifteen opcodes decoded, others ignored
// - three address bytes, fast reads add dummy
// - data streams; dual gives byte per 4 clocks
// - program 1..256 bytes, status write one; program byte count is not capped here
// - 90h ids after dummies; 9Fh three bytes
// - read data leaves on serial output
// - ABh repeats part code after three dummies
// - 06h sets write-enable latch
// - write-type needs latch set beforehand
// - 04h clears write-enable latch
// - latch cleared at reset and cycle end
// - status msb first, changes on falling edge
// - status repeats with fresh contents
// - status read allowed at any time
// - protect range bits in positions 4..2
// - lock bit with wp low blocks status write
// - status write touches bits 7,5,4,3,2 only
// - busy held through status write cycle
`timescale 1ns/10ps
module sfid_dev
  import sfid_pkg::*;
#(
  parameter logic [7:0] MAKER_CODE = 8'h5a,  // arbitrary value
  parameter logic [7:0] PART_CODE  = 8'h21,  // arbitrary value
  parameter logic [7:0] MEM_TYPE   = 8'h40,  // arbitrary value
  parameter logic [7:0] CAPACITY   = 8'h07   // arbitrary value
) (
  input  wire logic        clk,
  input  wire logic        srst,
  sfid_link_if.dev         link,
  input  wire logic        wp_n,
  input  wire logic        cyc_done,
  input  wire logic [7:0]  mem_rd_data,
  output logic      [23:0] mem_addr,
  output logic      [7:0]  cmd_op,
  output logic             cmd_go,
  output logic             prog_vld,
  output logic      [7:0]  prog_byte,
  output logic      [7:0]  status_nv,
  output logic             busy
);
  logic [3:0]  lnk_s;
  logic [3:0]  lnk_rise;
  logic [3:0]  lnk_fall;
  sfid_frame_e fr_r;
  logic [6:0]  in_sh_r;
  logic [2:0]  bit_cnt_r;
  logic [3:0]  byte_idx_r;
  logic        write_enable_latch_r;
  logic [7:0]  stat_wr_r;
  logic        ld_r;
  sfid_src_e   ld_src_r;
  sfid_src_e   src_nxt;
  logic [7:0]  out_sh_r;
  logic        out_act_r;
  logic        dual_r;

  // cs_n, sclk, io, wp_n all come from pins
  sfid_sync #(.W(4), .INIT(4'h9)) u_sync (
    .clk  (clk),
    .srst (srst),
    .d    ({link.cs_n, link.sclk, link.io_in, wp_n}),
    .q    (lnk_s),
    .rise (lnk_rise),
    .fall (lnk_fall)
  );

  wire       frame_begin = lnk_fall[3];
  wire       frame_end   = lnk_rise[3];
  wire       clk_up      = lnk_rise[2] & ~lnk_s[3];
  wire       clk_dn      = lnk_fall[2] & ~lnk_s[3];
  wire [7:0] rx_byte     = {in_sh_r, lnk_s[1]};
  wire       byte_done   = clk_up && (bit_cnt_r == BIT_LAST);
  wire [7:0] op_now      = (fr_r == FR_OPC) ? rx_byte : cmd_op;
  wire       locked      = status_nv[ST_LOCK] && !lnk_s[0];
  wire [7:0] stat_now    = {status_nv[7:2], write_enable_latch_r, busy};

  function automatic logic is_write(input logic [7:0] op);
    is_write = (op == OP_WR_STAT) || (op == OP_PROG) ||
               (op == OP_ERASE64) || (op == OP_ERASE4) ||
               (op == OP_ERASE_ALL);
  endfunction : is_write

  function automatic logic is_known(input logic [7:0] op);
    case (op)
      OP_WR_EN, OP_WR_DIS, OP_RD_STAT, OP_WR_STAT, OP_RD, OP_FAST_RD,
      OP_DUAL_RD, OP_PROG, OP_ERASE64, OP_ERASE4, OP_ERASE_ALL,
      OP_PWR_DOWN, OP_PART_ID, OP_MFR_ID, OP_JEDEC_ID: is_known = 1'b1;
      default: is_known = 1'b0;
    endcase
  endfunction : is_known

  function automatic logic has_addr(input logic [7:0] op);
    has_addr = (op == OP_RD) || (op == OP_FAST_RD) ||
               (op == OP_DUAL_RD) || (op == OP_PROG) ||
               (op == OP_ERASE64) || (op == OP_ERASE4);
  endfunction : has_addr

  wire refuse = (busy && (rx_byte != OP_RD_STAT)) ||
                !is_known(rx_byte) ||
                (is_write(rx_byte) && !write_enable_latch_r);

  wire reload = clk_up && (fr_r != FR_IDLE) && (fr_r != FR_SKIP) &&
                !((fr_r == FR_OPC) && refuse) &&
                (dual_r ? (bit_cnt_r[1:0] == DUAL_LAST)
                        : (bit_cnt_r == BIT_LAST));

  always_ff @(posedge clk) begin
    if (srst) begin
      fr_r <= FR_IDLE;
    end else begin
      case (fr_r)
        FR_IDLE: if (frame_begin) fr_r <= FR_OPC;
        FR_OPC: begin
          if (frame_end) fr_r <= FR_IDLE;
          else if (byte_done) fr_r <= refuse ? FR_SKIP : FR_BODY;
        end
        FR_BODY, FR_SKIP: if (frame_end) fr_r <= FR_IDLE;
        default: fr_r <= FR_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst || frame_begin) begin
      in_sh_r    <= '0;
      bit_cnt_r  <= '0;
      byte_idx_r <= IDX_OPC;
    end else if (clk_up) begin
      in_sh_r   <= rx_byte[6:0];
      bit_cnt_r <= bit_cnt_r + 3'h1;
      if (byte_done && byte_idx_r != IDX_MAX) byte_idx_r <= byte_idx_r + 4'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) cmd_op <= '0;
    else if (byte_done && fr_r == FR_OPC) cmd_op <= rx_byte;
  end

  // what the next outgoing byte is made of
  always_comb begin
    src_nxt = SRC_NONE;
    case (op_now)
      OP_RD_STAT: src_nxt = SRC_STAT;
      OP_RD:
        if (byte_idx_r >= IDX_ADDR_LAST) src_nxt = SRC_MEM;
      OP_FAST_RD, OP_DUAL_RD:
        if (byte_idx_r >= IDX_DUMMY) src_nxt = SRC_MEM;
      OP_PART_ID:
        if (byte_idx_r >= IDX_ADDR_LAST) src_nxt = SRC_PART;
      OP_MFR_ID: begin
        if (byte_idx_r == IDX_ADDR_LAST) src_nxt = SRC_MAKER;
        else if (byte_idx_r == IDX_DUMMY) src_nxt = SRC_PART;
      end
      OP_JEDEC_ID: begin
        if (byte_idx_r == IDX_OPC) src_nxt = SRC_MAKER;
        else if (byte_idx_r == IDX_ADDR_FIRST) src_nxt = SRC_TYPE;
        else if (byte_idx_r == IDX_CAP) src_nxt = SRC_CAP;
      end
      default: src_nxt = SRC_NONE;
    endcase
  end

  // one clk of delay lets mem_addr settle before the array is read
  always_ff @(posedge clk) begin
    if (srst || frame_end) begin
      ld_r     <= 1'b0;
      ld_src_r <= SRC_NONE;
      dual_r   <= 1'b0;
    end else begin
      ld_r     <= reload;
      ld_src_r <= src_nxt;
      if (reload && op_now == OP_DUAL_RD && src_nxt == SRC_MEM)
        dual_r <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      mem_addr <= '0;
    end else if (fr_r == FR_BODY && byte_done && has_addr(cmd_op) &&
                 byte_idx_r >= IDX_ADDR_FIRST &&
                 byte_idx_r <= IDX_ADDR_LAST) begin
      mem_addr <= {mem_addr[15:0], rx_byte};
    end else if (ld_r && ld_src_r == SRC_MEM) begin
      mem_addr <= mem_addr + 24'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst || frame_begin || frame_end) begin
      out_sh_r         <= '0;
      out_act_r        <= 1'b0;
      link.so          <= 1'b0;
      link.dev_io_o    <= 1'b0;
      link.dev_io_oe_n <= 1'b1;
    end else if (ld_r) begin
      out_act_r <= (ld_src_r != SRC_NONE);
      case (ld_src_r)
        SRC_STAT:  out_sh_r <= stat_now;
        SRC_MEM:   out_sh_r <= mem_rd_data;
        SRC_MAKER: out_sh_r <= MAKER_CODE;
        SRC_PART:  out_sh_r <= PART_CODE;
        SRC_TYPE:  out_sh_r <= MEM_TYPE;
        SRC_CAP:   out_sh_r <= CAPACITY;
        default:   out_sh_r <= '0;
      endcase
    end else if (clk_dn && out_act_r) begin
      link.so <= out_sh_r[7];
      if (dual_r) begin
        link.dev_io_o    <= out_sh_r[6];
        link.dev_io_oe_n <= 1'b0;
        out_sh_r         <= {out_sh_r[5:0], 2'b00};
      end else begin
        out_sh_r <= {out_sh_r[6:0], 1'b0};
      end
    end
  end

  // a frame acts only if it closes on a byte boundary
  wire commit = frame_end && fr_r == FR_BODY && bit_cnt_r == '0;
  logic go_now;
  always_comb begin
    go_now = 1'b0;
    case (cmd_op)
      OP_WR_STAT: go_now = (byte_idx_r == LEN_WSTAT) && !locked;
      OP_PROG:    go_now = (byte_idx_r >= LEN_PROG_MIN);
      OP_ERASE64, OP_ERASE4: go_now = (byte_idx_r == LEN_ERASE);
      OP_ERASE_ALL, OP_PWR_DOWN: go_now = (byte_idx_r == LEN_OPC);
      default: go_now = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cmd_go    <= 1'b0;
      busy      <= 1'b0;
      prog_vld  <= 1'b0;
      prog_byte <= '0;
      stat_wr_r <= '0;
      status_nv <= ST_NV_RST;
    end else begin
      cmd_go   <= commit && go_now;
      prog_vld <= fr_r == FR_BODY && byte_done && cmd_op == OP_PROG &&
                  byte_idx_r >= IDX_DUMMY;
      if (byte_done) prog_byte <= rx_byte;
      if (fr_r == FR_BODY && byte_done && cmd_op == OP_WR_STAT &&
          byte_idx_r == IDX_ADDR_FIRST) stat_wr_r <= rx_byte;
      if (commit && go_now && cmd_op != OP_PWR_DOWN) busy <= 1'b1;
      else if (cyc_done) busy <= 1'b0;
      if (commit && go_now && cmd_op == OP_WR_STAT)
        status_nv <= (status_nv & ~ST_WR_MASK) | (stat_wr_r & ST_WR_MASK);
    end
  end

  // set wins over the clear from cycle completion
  always_ff @(posedge clk) begin
    if (srst) write_enable_latch_r <= 1'b0;
    else if (commit && cmd_op == OP_WR_EN) write_enable_latch_r <= 1'b1;
    else if (commit && cmd_op == OP_WR_DIS) write_enable_latch_r <= 1'b0;
    else if (cyc_done) write_enable_latch_r <= 1'b0;
  end
endmodule : sfid_dev

// ==== sfid_host.sv ====
// host end: byte engine on the serial link, ordered over AHB-Lite
// assumes software sequences select, opcode, address and data bytes
`timescale 1ns/10ps
module sfid_host
  import sfid_pkg::*;
#(
  parameter int HALF_DIV = LINK_HALF_CYC
) (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  sfid_link_if.host        link
);
  localparam int DIV_W = $clog2(HALF_DIV + 1);
  localparam logic [DIV_W-1:0] DIV_END = DIV_W'(HALF_DIV - 1);

  logic [1:0]       rx_s;
  logic             wr_ph_r;
  logic [3:0]       wr_off_r;
  logic             wr_ok_r;
  logic             dual_r;
  logic             busy_r;
  logic [7:0]       rx_r;
  logic [7:0]       tx_sh_r;
  logic [3:0]       bits_r;
  logic [DIV_W-1:0] div_r;

  // so and the shared io line come from the far end
  sfid_sync #(.W(2), .INIT(2'b11)) u_sync (
    .clk  (clk),
    .srst (srst),
    .d    ({link.so, link.io_in}),
    .q    (rx_s),
    .rise (),
    .fall ()
  );

  wire ap_take = hsel && hready && htrans == HTRANS_NONSEQ;
  wire ap_ok   = haddr[31:4] == 28'h0;
  wire start   = wr_ph_r && wr_ok_r && wr_off_r == HA_DATA && !busy_r;
  wire ctrl_wr = wr_ph_r && wr_ok_r && wr_off_r == HA_CTRL;

  always_ff @(posedge clk) begin
    if (srst) begin
      wr_ph_r   <= 1'b0;
      wr_off_r  <= '0;
      wr_ok_r   <= 1'b0;
      hrdata    <= '0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      wr_ph_r   <= ap_take && hwrite;
      wr_off_r  <= haddr[3:0];
      wr_ok_r   <= ap_ok;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (ap_take && !hwrite) begin
        hrdata <= '0;
        if (ap_ok && haddr[3:0] == HA_CTRL)
          hrdata <= {30'h0, dual_r, ~link.cs_n};
        else if (ap_ok && haddr[3:0] == HA_DATA)
          hrdata <= {24'h0, rx_r};
        else if (ap_ok && haddr[3:0] == HA_STAT)
          hrdata <= {31'h0, busy_r};
      end
    end
  end

  // io is released in dual mode so the far end can drive it
  always_ff @(posedge clk) begin
    if (srst) begin
      link.cs_n         <= 1'b1;
      link.host_io_oe_n <= 1'b0;
      dual_r            <= 1'b0;
    end else if (ctrl_wr) begin
      link.cs_n         <= ~hwdata[HC_SEL];
      link.host_io_oe_n <= hwdata[HC_DUAL];
      dual_r            <= hwdata[HC_DUAL];
    end
  end

  // mode 0 clock; input sampled just before each falling edge
  always_ff @(posedge clk) begin
    if (srst) begin
      link.sclk      <= 1'b0;
      link.host_io_o <= 1'b0;
      busy_r         <= 1'b0;
      rx_r           <= '0;
      tx_sh_r        <= '0;
      bits_r         <= '0;
      div_r          <= '0;
    end else if (start) begin
      tx_sh_r        <= hwdata[7:0];
      link.host_io_o <= hwdata[7];
      bits_r         <= dual_r ? HBITS_DUAL : HBITS_SINGLE;
      busy_r         <= 1'b1;
      div_r          <= '0;
    end else if (busy_r) begin
      if (div_r == DIV_END) begin
        div_r     <= '0;
        link.sclk <= ~link.sclk;
        if (link.sclk) begin
          rx_r <= dual_r ? {rx_r[5:0], rx_s[1], rx_s[0]}
                         : {rx_r[6:0], rx_s[1]};
          tx_sh_r        <= {tx_sh_r[6:0], 1'b0};
          link.host_io_o <= tx_sh_r[6];
          bits_r         <= bits_r - 4'h1;
          if (bits_r == 4'h1) busy_r <= 1'b0;
        end
      end else begin
        div_r <= div_r + DIV_W'(1);
      end
    end
  end
endmodule : sfid_host

// ==== sfid_link_checker.sv ====
// assertions on the serial link joining host and decoder ends
// assumes link wires are sampled by clk; HALF_DIV as in the host
`timescale 1ns/10ps
module sfid_link_checker #(
  parameter int HALF_DIV = 4
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic so,
  input wire logic host_io_o,
  input wire logic host_io_oe_n,
  input wire logic dev_io_o,
  input wire logic dev_io_oe_n,
  input wire logic io_in
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  int hi_cnt;
  // length of the high phase, checked at each fall
  always_ff @(posedge clk) begin
    if (srst || !sclk) hi_cnt <= 0;
    else hi_cnt <= hi_cnt + 1;
  end
  property p_clk_idle; cs_n |-> !sclk; endproperty
  a_clk_idle: assert property (p_clk_idle)
    else $error("link clock active while deselected");
  property p_sclk_half; $fell(sclk) |-> hi_cnt == HALF_DIV; endproperty
  a_sclk_half: assert property (p_sclk_half)
    else $error("link clock high phase has wrong length");
  property p_host_hold; $rose(sclk) |-> $stable(host_io_o); endproperty
  a_host_hold: assert property (p_host_hold)
    else $error("host data moved at rising link clock");
  property p_cs_edge; $changed(cs_n) |-> !sclk; endproperty
  a_cs_edge: assert property (p_cs_edge)
    else $error("select moved while link clock high");
  property p_so_fall; $changed(so) |-> !sclk; endproperty
  a_so_fall: assert property (p_so_fall)
    else $error("serial out moved while link clock high");
  property p_dev_drive; $fell(dev_io_oe_n) |-> !cs_n && !sclk; endproperty
  a_dev_drive: assert property (p_dev_drive)
    else $error("device took io line outside a data fall");
  property p_dev_release;
    $rose(cs_n) |-> ##[1:8] dev_io_oe_n;
  endproperty
  a_dev_release: assert property (p_dev_release)
    else $error("device kept io line after frame end");
  property p_no_fight; !dev_io_oe_n |-> host_io_oe_n; endproperty
  a_no_fight: assert property (p_no_fight)
    else $error("both ends drive io line");
  c_frame: cover property ($fell(cs_n));
  c_dual: cover property ($fell(dev_io_oe_n));
  c_end: cover property ($rose(cs_n));
endmodule : sfid_link_checker

// ==== tb_top.sv ====
// self-checking bench: host over AHB-Lite, decoder user side driven
// assumes a combinational array model behind mem_addr
`timescale 1ns/10ps
module tb_top;
  import sfid_pkg::*;
  localparam int         HD = 4;
  localparam logic [7:0] MK = 8'h3c;  // arbitrary value
  localparam logic [7:0] PT = 8'h4e;  // arbitrary value
  localparam logic [7:0] MT = 8'h61;  // arbitrary value
  localparam logic [7:0] CP = 8'h15;  // arbitrary value
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [31:0] hwdata = '0;
  logic [1:0]  htrans = '0;
  logic [2:0]  hsize = 3'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hrdata, r;
  logic        hreadyout, hresp, cmd_go, prog_vld, busy;
  logic        wp_n = 1'b1;
  logic        cyc_done = 1'b0;
  logic [7:0]  mem_rd_data, cmd_op, prog_byte, status_nv, rxb;
  logic [7:0]  rx [8];
  logic [23:0] mem_addr;
  int          num_errors = 0, num_checks = 0;
  int          n_go = 0, n_prog = 0, cyc = 0, g;

  sfid_link_if link ();
  sfid_host #(.HALF_DIV(HD)) sfid_host_i (.clk(clk), .srst(srst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .link(link));
  sfid_dev #(.MAKER_CODE(MK), .PART_CODE(PT), .MEM_TYPE(MT),
    .CAPACITY(CP)) sfid_dev_i (.clk(clk), .srst(srst), .link(link),
    .wp_n(wp_n), .cyc_done(cyc_done), .mem_rd_data(mem_rd_data),
    .mem_addr(mem_addr), .cmd_op(cmd_op), .cmd_go(cmd_go),
    .prog_vld(prog_vld), .prog_byte(prog_byte), .status_nv(status_nv),
    .busy(busy));
  sfid_link_checker #(.HALF_DIV(HD)) sfid_link_checker_i (.clk(clk),
    .srst(srst), .cs_n(link.cs_n), .sclk(link.sclk), .so(link.so),
    .host_io_o(link.host_io_o), .host_io_oe_n(link.host_io_oe_n),
    .dev_io_o(link.dev_io_o), .dev_io_oe_n(link.dev_io_oe_n),
    .io_in(link.io_in));
  // array content is a known function of the address
  assign mem_rd_data = mem_addr[7:0] ^ 8'ha5;

  initial forever #2 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cmd_go === 1'b1) n_go <= n_go + 1;
    if (prog_vld === 1'b1) n_prog <= n_prog + 1;
    if (cyc == 40000) begin
      num_errors++;
      close_out();
    end
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : close_out
  task automatic chk8(input string nm, input logic [7:0] e,
                      input logic [7:0] s);
    num_checks++;
    if (s !== e) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", nm, e, s);
    end
  endtask : chk8
  // entered just after an edge; address held until hready seen
  task automatic ahb(input logic [31:0] a, input logic w,
                     input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    hsize <= 3'h2;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    q = hrdata;
  endtask : ahb
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [31:0] q;
    ahb({28'h0, a}, 1'b1, {24'h0, d}, q);
  endtask : wr
  task automatic put(input logic [7:0] b);
    logic [31:0] q;
    wr(HA_DATA, b);
    q = 32'h1;
    while (q[HS_BUSY] !== 1'b0) ahb({28'h0, HA_STAT}, 1'b0, 32'h0, q);
    ahb({28'h0, HA_DATA}, 1'b0, 32'h0, q);
    rxb = q[7:0];
  endtask : put
  // cs high long enough for the decoder to commit and resync
  task automatic close_f(input logic [7:0] c);
    wr(HA_CTRL, c);
    repeat (8) @(posedge clk);
  endtask : close_f
  task automatic frame(input logic [63:0] b, input int n, input bit k);
    wr(HA_CTRL, 8'h01);
    for (int i = 0; i < n; i++) begin
      put(b[63-8*i -: 8]);
      rx[i] = rxb;
    end
    if (!k) close_f(8'h00);
  endtask : frame
  task automatic pulse();
    cyc_done <= 1'b1;
    @(posedge clk);
    cyc_done <= 1'b0;
    @(posedge clk);
  endtask : pulse

  initial begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    repeat (8) @(posedge clk);
    ahb(32'h10, 1'b0, 32'h0, r);
    chk8("unmapped", 8'h00, r[7:0]);
    frame({OP_RD_STAT, 56'h0}, 2, 0);
    chk8("status", 8'h00, rx[1]);
    frame({OP_WR_EN, 56'h0}, 1, 0);
    frame({OP_RD_STAT, 56'h0}, 3, 0);
    chk8("status", 8'h02, rx[1]);
    chk8("status", 8'h02, rx[2]);
    frame({OP_WR_DIS, 56'h0}, 1, 0);
    frame({OP_RD_STAT, 56'h0}, 2, 0);
    chk8("status", 8'h00, rx[1]);
    $display("test latch done");
    frame({OP_WR_STAT, 8'hff, 48'h0}, 2, 0);
    chk8("status_nv", 8'h00, status_nv);
    chk8("commits", 8'h00, 8'(n_go));
    frame({OP_WR_EN, 56'h0}, 1, 0);
    frame({OP_WR_STAT, 8'hff, 48'h0}, 2, 0);
    chk8("status_nv", ST_WR_MASK, status_nv);
    chk8("busy", 8'h01, {7'h0, busy});
    frame({OP_RD_STAT, 56'h0}, 3, 0);
    chk8("status", 8'hbf, rx[2]);
    frame({OP_RD, 24'h000010, 32'h0}, 5, 0);
    chk8("busy read", 8'h00, rx[4]);
    pulse();
    frame({OP_RD_STAT, 56'h0}, 2, 0);
    chk8("status", 8'hbc, rx[1]);
    wp_n <= 1'b0;
    frame({OP_WR_EN, 56'h0}, 1, 0);
    frame({OP_WR_STAT, 56'h0}, 2, 0);
    chk8("status_nv", 8'hbc, status_nv);
    wp_n <= 1'b1;
    frame({OP_WR_EN, 56'h0}, 1, 0);
    frame({OP_WR_STAT, 56'h0}, 2, 0);
    chk8("status_nv", 8'h00, status_nv);
    pulse();
    $display("test status write done");
    frame({OP_RD, 24'h123456, 32'h0}, 6, 0);
    chk8("read", 8'h56 ^ 8'ha5, rx[4]);
    chk8("read", 8'h57 ^ 8'ha5, rx[5]);
    frame({OP_FAST_RD, 24'h000020, 32'h0}, 6, 0);
    chk8("fast read", 8'h20 ^ 8'ha5, rx[5]);
    frame({OP_DUAL_RD, 24'h000030, 32'h0}, 4, 1);
    // io released before the dummy ends: device drives it at that fall
    wr(HA_CTRL, 8'h03);
    put(8'h00);
    put(8'h00);
    put(8'h00);
    chk8("dual read", 8'h30 ^ 8'ha5, rxb);
    close_f(8'h02);
    close_f(8'h00);
    $display("test reads done");
    frame({OP_PART_ID, 56'h0}, 6, 0);
    chk8("part", PT, rx[4]);
    chk8("part", PT, rx[5]);
    frame({OP_MFR_ID, 56'h0}, 6, 0);
    chk8("maker", MK, rx[4]);
    chk8("part", PT, rx[5]);
    frame({OP_JEDEC_ID, 56'h0}, 4, 0);
    chk8("maker", MK, rx[1]);
    chk8("type", MT, rx[2]);
    chk8("capacity", CP, rx[3]);
    $display("test ids done");
    g = n_go;
    frame({OP_WR_EN, 56'h0}, 1, 0);
    frame({OP_ERASE4, 24'h001000, 32'h0}, 4, 1);
    wr(HA_CTRL, 8'h03);
    ahb({28'h0, HA_CTRL}, 1'b0, 32'h0, r);
    chk8("select", 8'h03, r[7:0]);
    chk8("hresp", 8'h00, {7'h0, hresp});
    put(8'h00);
    close_f(8'h02);
    close_f(8'h00);
    chk8("commits", 8'(g), 8'(n_go));
    frame({OP_ERASE4, 24'h001000, 32'h0}, 4, 0);
    chk8("commits", 8'(g + 1), 8'(n_go));
    chk8("opcode", OP_ERASE4, cmd_op);
    pulse();
    frame({OP_WR_EN, 56'h0}, 1, 0);
    frame({OP_PROG, 24'h000100, 8'h11, 8'h22, 16'h0}, 6, 0);
    chk8("prog bytes", 8'h02, 8'(n_prog));
    chk8("prog byte", 8'h22, prog_byte);
    chk8("opcode", OP_PROG, cmd_op);
    pulse();
    frame({OP_RD_STAT, 56'h0}, 2, 0);
    chk8("status", 8'h00, rx[1]);
    frame({OP_WR_EN, 56'h0}, 1, 0);
    frame({OP_ERASE64, 24'h020000, 32'h0}, 4, 0);
    chk8("opcode", OP_ERASE64, cmd_op);
    chk8("busy", 8'h01, {7'h0, busy});
    pulse();
    frame({OP_WR_EN, 56'h0}, 1, 0);
    frame({OP_ERASE_ALL, 56'h0}, 1, 0);
    chk8("opcode", OP_ERASE_ALL, cmd_op);
    pulse();
    frame({OP_PWR_DOWN, 56'h0}, 1, 0);
    chk8("opcode", OP_PWR_DOWN, cmd_op);
    chk8("busy", 8'h00, {7'h0, busy});
    chk8("commits", 8'(g + 5), 8'(n_go));
    $display("test erase and program done");
    close_out();
  end
endmodule : tb_top
